// >>> verilog/twbc_pkg.sv
// package for the two-wire target bus-condition block
// assumes a single system clock domain sampling the serial pins
package twbc_pkg;
  // ==========================================================
  // word framing
  localparam int WORD_BITS = 8;
  localparam logic [3:0] ADDR_FAMILY = 4'ha;
  localparam logic [2:0] STRAP_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ==========================================================
  // protocol states, one-hot
  typedef enum logic [4:0] {
    TWBC_STANDBY = 5'h01,
    TWBC_ADDR = 5'h02,
    TWBC_RECV = 5'h04,
    TWBC_ACK = 5'h08,
    TWBC_SEND = 5'h10
  } twbc_state_t;
  // sampled line levels travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } twbc_lines_t;
  // one received word handed to the user side
  typedef struct packed {
    logic isAddr;
    logic [7:0] data;
  } twbc_word_t;
endpackage

// >>> verilog/twbc_sync.sv
// two-flop synchroniser for the serial pins, with edge and condition decode
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
module twbc_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire twbc_pkg::twbc_lines_t pinIn,
  output twbc_pkg::twbc_lines_t lines,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  // ==========================================================
  // synchroniser and history
  twbc_pkg::twbc_lines_t meta_reg, meta_next;
  twbc_pkg::twbc_lines_t sync_reg, sync_next;
  twbc_pkg::twbc_lines_t prev_reg, prev_next;
  // first stage read only by second stage
  always_comb begin
    meta_next = pinIn;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end
  // idle bus is high on both lines
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end
  assign lines = sync_reg;
  assign sclRise = sync_reg.scl && !prev_reg.scl;
  assign sclFall = !sync_reg.scl && prev_reg.scl;
  // data moving while clock stays high is a condition, not data
  assign startSeen = sync_reg.scl && prev_reg.scl && prev_reg.sda && !sync_reg.sda;
  assign stopSeen = sync_reg.scl && prev_reg.scl && !prev_reg.sda && sync_reg.sda;
endmodule

// >>> verilog/twbc_target.sv
// two-wire memory target: conditions, word shift, acknowledge, standby
// assumes host drives scl; sda is open drain with external pull-up
`timescale 1ns/1ps
// Operation
// - data changes only while clock low
// - data line only pulled low or released
// - falling data with clock high starts
// - traffic ignored until a start arrives
// - rising data with clock high stops
// - stop after read enters standby
// - every word is eight clock cycles
// - acknowledge low through ninth clock
// - standby at reset and after stop
// - sample on rise, shift after fall
// - address mismatch returns standby silently
// - address bit zero selects read/write
module twbc_target #(
  parameter int WORD_BITS = twbc_pkg::WORD_BITS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrStrap,
  input wire logic busy,
  input wire logic [7:0] txData,
  output logic txTake,
  output twbc_pkg::twbc_word_t rxWord,
  output logic rxValid,
  output logic readMode,
  output logic standby
);
  // ==========================================================
  // pin decode
  twbc_pkg::twbc_lines_t pins;
  twbc_pkg::twbc_lines_t lines;
  logic sclRise, sclFall, startSeen, stopSeen;
  assign pins = '{scl: sclIn, sda: sdaIn};
  twbc_sync u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pinIn(pins),
    .lines(lines),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );
  // ==========================================================
  // protocol state
  twbc_pkg::twbc_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic isAddr_reg, isAddr_next;
  logic read_reg, read_next;
  logic ackMode_reg, ackMode_next; // 1: we drive ack, 0: host acks
  logic drive_reg, drive_next;
  // host ack seen on the ninth rise; the load waits for its fall so sda never moves with scl high
  logic hostAck_reg, hostAck_next;
  logic stopPend_reg, stopPend_next;
  logic [2:0] strap_reg, strap_next;
  logic strapCaught_reg, strapCaught_next;
  logic rxValid_reg, rxValid_next;
  logic txTake_reg, txTake_next;
  twbc_pkg::twbc_word_t rxWord_reg, rxWord_next;
  logic [7:0] rxByte;
  logic lastBit;
  assign rxByte = {shift_reg[6:0], lines.sda};
  assign lastBit = (bitCnt_reg == 4'(WORD_BITS - 1));
  // next-state logic; conditions take priority over clock edges
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    isAddr_next = isAddr_reg;
    read_next = read_reg;
    ackMode_next = ackMode_reg;
    drive_next = drive_reg;
    hostAck_next = hostAck_reg;
    stopPend_next = stopPend_reg;
    strap_next = strap_reg;
    strapCaught_next = 1'b1;
    rxValid_next = 1'b0;
    txTake_next = 1'b0;
    rxWord_next = rxWord_reg;
    // strap caught once after reset release
    if (!strapCaught_reg) begin
      strap_next = addrStrap;
    end
    if (startSeen) begin
      // restart address reception, any word in flight dropped
      state_next = twbc_pkg::TWBC_ADDR;
      bitCnt_next = 4'h0;
      isAddr_next = 1'b1;
      drive_next = 1'b0;
      hostAck_next = 1'b0;
      stopPend_next = 1'b0;
    end else if (stopSeen) begin
      // standby waits for internal work to drain
      state_next = twbc_pkg::TWBC_STANDBY;
      drive_next = 1'b0;
      hostAck_next = 1'b0;
      stopPend_next = 1'b1;
    end else begin
      if (stopPend_reg && !busy) begin
        stopPend_next = 1'b0;
      end
      case (state_reg)
        twbc_pkg::TWBC_STANDBY: begin
          // nothing but a start leaves here
          drive_next = 1'b0;
        end
        twbc_pkg::TWBC_ADDR, twbc_pkg::TWBC_RECV: begin
          if (sclRise) begin
            shift_next = rxByte;
            bitCnt_next = bitCnt_reg + 4'h1;
            if (lastBit) begin
              bitCnt_next = 4'h0;
              if (isAddr_reg && (rxByte[7:4] != twbc_pkg::ADDR_FAMILY ||
                  rxByte[3:1] != strap_reg)) begin
                state_next = twbc_pkg::TWBC_STANDBY;
              end else begin
                state_next = twbc_pkg::TWBC_ACK;
                ackMode_next = 1'b1;
                rxValid_next = 1'b1;
                rxWord_next = '{isAddr: isAddr_reg, data: rxByte};
                if (isAddr_reg) begin
                  read_next = rxByte[0];
                end
              end
            end
          end
        end
        twbc_pkg::TWBC_ACK: begin
          if (ackMode_reg && sclFall && !drive_reg) begin
            drive_next = 1'b1; // hold low for the ninth clock
          end else if (sclFall && (drive_reg || hostAck_reg)) begin
            // ninth clock over: release and receive, or load the next byte and drive its first bit
            drive_next = 1'b0;
            hostAck_next = 1'b0;
            isAddr_next = 1'b0;
            if (read_reg) begin
              state_next = twbc_pkg::TWBC_SEND;
              shift_next = txData;
              txTake_next = 1'b1;
              drive_next = !txData[7];
            end else begin
              state_next = twbc_pkg::TWBC_RECV;
            end
          end else if (!ackMode_reg && sclRise) begin
            // host nack ends the read; an ack only arms the load at the fall
            if (lines.sda) begin
              state_next = twbc_pkg::TWBC_STANDBY;
            end else begin
              hostAck_next = 1'b1;
            end
          end
        end
        twbc_pkg::TWBC_SEND: begin
          if (sclFall) begin
            bitCnt_next = bitCnt_reg + 4'h1;
            if (lastBit) begin
              bitCnt_next = 4'h0;
              drive_next = 1'b0;
              state_next = twbc_pkg::TWBC_ACK;
              ackMode_next = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              drive_next = !shift_reg[6];
            end
          end
        end
        default: state_next = twbc_pkg::TWBC_STANDBY;
      endcase
    end
  end
  // registers only; power-up lands in standby with the line released
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= twbc_pkg::TWBC_STANDBY;
      shift_reg <= twbc_pkg::BYTE_RESET;
      bitCnt_reg <= 4'h0;
      isAddr_reg <= 1'b1;
      read_reg <= 1'b0;
      ackMode_reg <= 1'b0;
      drive_reg <= 1'b0;
      hostAck_reg <= 1'b0;
      stopPend_reg <= 1'b0;
      strap_reg <= twbc_pkg::STRAP_RESET;
      strapCaught_reg <= 1'b0;
      rxValid_reg <= 1'b0;
      txTake_reg <= 1'b0;
      rxWord_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      isAddr_reg <= isAddr_next;
      read_reg <= read_next;
      ackMode_reg <= ackMode_next;
      drive_reg <= drive_next;
      hostAck_reg <= hostAck_next;
      stopPend_reg <= stopPend_next;
      strap_reg <= strap_next;
      strapCaught_reg <= strapCaught_next;
      rxValid_reg <= rxValid_next;
      txTake_reg <= txTake_next;
      rxWord_reg <= rxWord_next;
    end
  end
  // open drain: only ever drive a low
  assign sdaOut = 1'b0;
  assign sdaOe = drive_reg;
  assign rxWord = rxWord_reg;
  assign rxValid = rxValid_reg;
  assign txTake = txTake_reg;
  assign readMode = read_reg;
  assign standby = (state_reg == twbc_pkg::TWBC_STANDBY) && !stopPend_reg;
endmodule

// >>> verif/twbc_target_asserts.sv
// checker for the two-wire target: line timing, acknowledge, standby
// assumes host scl phases of 8 sys_clk cycles each
`timescale 1ns/1ps
module twbc_target_asserts #(
  parameter int WORD_BITS = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [2:0] addrStrap,
  input wire logic busy,
  input wire logic [7:0] txData,
  input wire logic txTake,
  input wire twbc_pkg::twbc_word_t rxWord,
  input wire logic rxValid,
  input wire logic readMode,
  input wire logic standby
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // data line driving
  chk_only_pulls: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("sda driven high");
  chk_oe_clk_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved with scl high");
  chk_high_hold: assert property ($rose(sclIn) && sdaOe |=> $stable(sdaOe) [*7])
    else $error("pull dropped in high phase");
  // acknowledge slot opens after a word and closes after the ninth clock
  chk_ack_slot: assert property (rxValid && !(rxWord.isAddr && rxWord.data[0]) |->
    ##[1:16] sdaOe ##[8:24] !sdaOe) else $error("ack slot wrong");
  chk_addr_match: assert property (rxValid && rxWord.isAddr |->
    rxWord.data[7:1] == {twbc_pkg::ADDR_FAMILY, addrStrap}) else $error("foreign address");
  chk_take_read: assert property (txTake |-> readMode)
    else $error("load outside read");
  // ====
  // standby entry and exit
  chk_reset_idle: assert property ($rose(rst_b) |-> standby)
    else $error("no standby at reset");
  chk_idle_quiet: assert property (standby |-> !sdaOe)
    else $error("pull in standby");
  chk_stop_idle: assert property (sclIn && $past(sclIn) && $rose(sdaIn) && !busy |->
    ##[1:8] standby) else $error("stop left device awake");
  chk_busy_wake: assert property ($past(busy) && busy && !$past(standby) |-> !standby)
    else $error("standby while busy");
endmodule
bind twbc_target twbc_target_asserts #(.WORD_BITS(WORD_BITS)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .addrStrap(addrStrap), .busy(busy), .txData(txData), .txTake(txTake),
  .rxWord(rxWord), .rxValid(rxValid), .readMode(readMode), .standby(standby)
);

// >>> verif/twbc_host_model.sv
// host controller model: drives scl, pulls or releases sda
// assumes 100 MHz sys_clk; one scl period is 16 cycles
`timescale 1ns/1ps
module twbc_host_model (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaOe
);
  // idle bus: clock parked high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // data falls while clock high
  task automatic start();
    sdaOe <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sdaOe <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(4);
  endtask
  // data rises while clock high
  task automatic stop();
    sdaOe <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sdaOe <= 1'b0;
    wt(8);
  endtask
  // change only in low phase, sample mid-high; never drive high
  task automatic bitx(input logic b, output logic s);
    sdaOe <= !b;
    wt(4);
    scl <= 1'b1;
    wt(4);
    s = sdaWire;
    wt(4);
    scl <= 1'b0;
    wt(4);
  endtask
  // eight bits MSB first then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bitx(i > 0 ? d[i-1] : ak, q[i]);
  endtask
  // clock until data reads high, at most nine times, then start
  task automatic recover(output int n);
    sdaOe <= 1'b0;
    for (n = 1; n <= 9; n++) begin
      scl <= 1'b0;
      wt(8);
      scl <= 1'b1;
      wt(4);
      if (sdaWire) break;
      wt(4);
    end
    start();
  endtask
endmodule

// >>> verif/tb_two_wire_eeprom_bus_conditions.sv
// bench for the two-wire target, host model on the bus side
// assumes the host model paces scl at 160 ns
`timescale 1ns/1ps
module tb_two_wire_eeprom_bus_conditions;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] ADW = {twbc_pkg::ADDR_FAMILY, STRAP, 1'b0};
  logic sys_clk;
  logic rst_b;
  logic busy;
  logic [7:0] txData;
  logic sdaOe;
  logic hostOe;
  logic scl;
  logic readMode;
  logic standby;
  logic rxValid;
  logic sdaOut;
  logic txTake;
  twbc_pkg::twbc_word_t rxWord;
  twbc_pkg::twbc_word_t lastRx;
  int nRx;
  int nTake;
  int errors;
  int n_tests;
  int cycles;
  // open-drain wire with pull-up
  // device pulls low only when enabled with sdaOut low, so a high drive reads as released
  wire logic sdaWire = !hostOe && !(sdaOe && !sdaOut);
  twbc_target dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrStrap(STRAP), .busy(busy), .txData(txData), .txTake(txTake),
    .rxWord(rxWord), .rxValid(rxValid), .readMode(readMode), .standby(standby)
  );
  twbc_host_model host_u (.sys_clk(sys_clk), .sdaWire(sdaWire), .scl(scl), .sdaOe(hostOe));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  // capture words; cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (rxValid === 1'b1) begin
      nRx++;
      lastRx = rxWord;
    end
    if (txTake === 1'b1) begin
      nTake++;
    end
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_write();
    logic [8:0] q;
    host_u.start();
    host_u.xfer(ADW, 1'b1, q);
    check(q, {ADW, 1'b0});
    host_u.xfer(8'ha5, 1'b1, q);
    check(lastRx, {1'b0, 8'ha5});
    host_u.stop();
    check({8'h00, standby}, 9'h001);
  endtask
  // wrong family, then wrong strap: no ack, nothing delivered
  task automatic t_mismatch();
    logic [8:0] q;
    int n0;
    n0 = nRx;
    for (int k = 0; k < 2; k++) begin
      host_u.start();
      host_u.xfer(k == 0 ? {4'hb, STRAP, 1'b0} : {4'ha, 3'h2, 1'b0}, 1'b1, q);
      check({8'h00, q[0]}, 9'h001);
      host_u.xfer(8'h12, 1'b1, q);
      host_u.stop();
    end
    check(9'(nRx - n0), 9'h000);
  endtask
  task automatic t_read();
    logic [8:0] q;
    int t0;
    t0 = nTake;
    txData <= 8'hc3;
    host_u.start();
    host_u.xfer(ADW | 8'h01, 1'b1, q);
    txData <= 8'h3c;
    check({7'h00, q[0], readMode}, 9'h001);
    host_u.xfer(8'hff, 1'b0, q);
    check(q, {8'hc3, 1'b0});
    host_u.xfer(8'hff, 1'b1, q);
    check(q, {8'h3c, 1'b1});
    host_u.stop();
    check({8'h00, standby}, 9'h001);
    check(9'(nTake - t0), 9'h002);
  endtask
  // stop and restart mid-word, and a word without a start
  task automatic t_abort();
    logic [8:0] q;
    int n0;
    n0 = nRx;
    host_u.start();
    for (int i = 7; i > 3; i--) host_u.bitx(ADW[i], q[i]);
    host_u.stop();
    check({8'h00, standby}, 9'h001);
    host_u.xfer(ADW, 1'b1, q);
    check({8'h00, q[0]}, 9'h001);
    host_u.start();
    for (int i = 7; i > 4; i--) host_u.bitx(ADW[i], q[i]);
    host_u.start();
    host_u.xfer(ADW, 1'b1, q);
    check({q[0], 8'(nRx - n0)}, 9'h001);
    host_u.stop();
  endtask
  task automatic t_busy();
    logic [8:0] q;
    busy <= 1'b1;
    host_u.start();
    host_u.xfer(ADW, 1'b1, q);
    host_u.xfer(8'h77, 1'b1, q);
    host_u.stop();
    check({8'h00, standby}, 9'h000);
    busy <= 1'b0;
    host_u.wt(8);
    check({8'h00, standby}, 9'h001);
  endtask
  // host gives up after a read address; all-zero byte holds data low
  task automatic t_recover();
    logic [8:0] q;
    int n;
    txData <= 8'h00;
    host_u.start();
    host_u.xfer(ADW | 8'h01, 1'b1, q);
    host_u.recover(n);
    check(n[8:0], 9'h009);
    host_u.xfer(ADW, 1'b1, q);
    check({8'h00, q[0]}, 9'h000);
    host_u.stop();
  endtask
  initial begin
    rst_b = 1'b0;
    busy = 1'b0;
    txData = 8'h00;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_write();
    t_mismatch();
    t_read();
    t_abort();
    t_busy();
    t_recover();
    stop_test();
  end
endmodule
